// *** hdl/cadr_regs.sv ***
// relative card address and card descriptor registers of a read-only memory card
// assumes decoded command strobes and memory handshakes arrive on the card bus clock
`timescale 1ns/1ps
module cadr_regs (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire cadr_pkg::cadr_cmd_t i_cmd,
	input wire logic i_bit_ready,
	input wire logic i_mem_valid,
	output logic [15:0] o_rca,
	output logic o_selected,
	output logic o_desc_ready,
	output logic o_desc_valid,
	output logic o_desc_bit,
	output logic o_desc_last,
	output logic [11:0] o_blk_len,
	output logic o_blk_err,
	output logic o_addr_err,
	output logic o_write_reject,
	output logic o_read_go,
	output logic o_read_valid,
	output logic o_read_timeout
);
	logic [15:0] rca_q;
	logic selected_q;
	cadr_pkg::cadr_desc_st_t st_q;
	logic [6:0] idx_q;
	logic [127:0] desc_word_q;
	logic [127:0] sr_q;
	logic pend_q;
	logic desc_valid_q;
	logic desc_last_q;
	logic [11:0] blk_len_q;
	logic blk_err_q;
	logic addr_err_q;
	logic write_reject_q;
	logic read_go_q;
	logic read_valid_q;
	logic [6:0] crc;
	logic crc_en;
	logic crc_bit;
	logic tmr_busy;
	logic tmr_expired;
	logic [15:0] arg_addr;
	logic [32:0] read_end;
	logic read_ok;
	logic bit_taken;

	assign arg_addr = i_cmd.arg[cadr_pkg::RCA_ARG_LSB +: 16];
	assign read_end = {1'b0, i_cmd.arg} + {21'h0, blk_len_q};
	assign bit_taken = desc_valid_q && i_bit_ready;
	assign crc_en = (st_q == cadr_pkg::CADR_ST_CRC);
	assign crc_bit = cadr_pkg::DESC_BODY[7'(cadr_pkg::DESC_BODY_W - 1) - idx_q];

	// no alignment check: blocks may straddle physical blocks
	assign read_ok = (read_end <= 33'(cadr_pkg::CAPACITY_BYTES));

	assign o_rca = rca_q;
	assign o_selected = selected_q;
	assign o_desc_ready = st_q[1];
	assign o_desc_valid = desc_valid_q;
	assign o_desc_bit = sr_q[127];
	assign o_desc_last = desc_last_q;
	assign o_blk_len = blk_len_q;
	assign o_blk_err = blk_err_q;
	assign o_addr_err = addr_err_q;
	assign o_write_reject = write_reject_q;
	assign o_read_go = read_go_q;
	assign o_read_valid = read_valid_q;
	assign o_read_timeout = tmr_expired;

	cadr_crc7 u_crc (
		.i_clk_sys(i_clk_sys),
		.i_clear(i_rst),
		.i_en(crc_en),
		.i_bit(crc_bit),
		.o_crc(crc)
	);

	cadr_access_timer u_timer (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_start(read_go_q),
		.i_stop(i_mem_valid),
		.o_busy(tmr_busy),
		.o_expired(tmr_expired)
	);

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			rca_q <= cadr_pkg::RCA_DEFAULT;
		end
		else if (i_cmd.set_addr && arg_addr != cadr_pkg::RCA_RESERVED)
		begin
			rca_q <= arg_addr;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			selected_q <= 1'b0;
		end
		else if (i_cmd.select)
		begin
			// reserved address deselects every card; any other foreign address deselects us
			selected_q <= (arg_addr != cadr_pkg::RCA_RESERVED) && (arg_addr == rca_q);
		end
	end

	// checksum built once after reset, then the word is frozen
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			st_q <= cadr_pkg::CADR_ST_CRC;
			idx_q <= 7'h00;
			desc_word_q <= 128'h0;
			sr_q <= 128'h0;
			desc_valid_q <= 1'b0;
			desc_last_q <= 1'b0;
		end
		else
		begin
			case (st_q)
				cadr_pkg::CADR_ST_CRC:
				begin
					idx_q <= idx_q + 7'h01;
					if (idx_q == 7'(cadr_pkg::DESC_BODY_W - 1))
					begin
						st_q <= cadr_pkg::CADR_ST_LOAD;
					end
				end
				cadr_pkg::CADR_ST_LOAD:
				begin
					// only constants reach the word; nothing writes it later
					desc_word_q <= {cadr_pkg::DESC_BODY, crc, cadr_pkg::END_BIT};
					st_q <= cadr_pkg::CADR_ST_IDLE;
				end
				cadr_pkg::CADR_ST_IDLE:
				begin
					if (pend_q || i_cmd.send_desc)
					begin
						sr_q <= desc_word_q;
						idx_q <= 7'h00;
						desc_valid_q <= 1'b1;
						desc_last_q <= 1'b0;
						st_q <= cadr_pkg::CADR_ST_SEND;
					end
				end
				cadr_pkg::CADR_ST_SEND:
				begin
					if (bit_taken)
					begin
						sr_q <= {sr_q[126:0], 1'b0};
						idx_q <= idx_q + 7'h01;
						desc_last_q <= (idx_q == 7'h7e);
						if (desc_last_q)
						begin
							desc_valid_q <= 1'b0;
							st_q <= cadr_pkg::CADR_ST_IDLE;
						end
					end
				end
				default:
				begin
					st_q <= cadr_pkg::CADR_ST_CRC;
				end
			endcase
		end
	end

	// a request during the checksum pass is held, not dropped; in idle the clear wins and a new request is served directly
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			pend_q <= 1'b0;
		end
		else if (i_cmd.send_desc && st_q != cadr_pkg::CADR_ST_IDLE)
		begin
			pend_q <= 1'b1;
		end
		else if (st_q == cadr_pkg::CADR_ST_IDLE)
		begin
			pend_q <= 1'b0;
		end
	end

	// any length from one byte up to BLK_BYTES accepted
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			blk_len_q <= 12'(cadr_pkg::BLK_BYTES);
			blk_err_q <= 1'b0;
		end
		else if (i_cmd.set_blen)
		begin
			if (i_cmd.arg != 32'h0 && i_cmd.arg <= 32'(cadr_pkg::BLK_BYTES))
			begin
				blk_len_q <= i_cmd.arg[11:0];
				blk_err_q <= 1'b0;
			end
			else
			begin
				blk_err_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			write_reject_q <= 1'b0;
		end
		else
		begin
			write_reject_q <= i_cmd.write_req && desc_word_q[cadr_pkg::PERM_PROTECT_POS]
				|| i_cmd.write_req && desc_word_q[cadr_pkg::TEMP_PROTECT_POS]
				|| i_cmd.write_req && !o_desc_ready;
		end
	end

	// memory read start and delivery before the deadline
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			read_go_q <= 1'b0;
			read_valid_q <= 1'b0;
			addr_err_q <= 1'b0;
		end
		else
		begin
			read_go_q <= i_cmd.read_start && selected_q && read_ok && !tmr_busy;
			read_valid_q <= tmr_busy && i_mem_valid;
			if (i_cmd.read_start && selected_q)
			begin
				addr_err_q <= !read_ok;
			end
		end
	end

	// assertion helpers: descriptor bits leave in order
	logic [127:0] exp_q;
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst || !desc_valid_q)
		begin
			exp_q <= desc_word_q;
		end
		else if (bit_taken)
		begin
			exp_q <= {exp_q[126:0], 1'b0};
		end
	end

	property p_rca_reset;
		@(posedge i_clk_sys) $fell(i_rst) |-> rca_q == cadr_pkg::RCA_DEFAULT;
	endproperty
	a_rca_reset: assert property (p_rca_reset)
		else $error("address not at default after reset");

	property p_rca_hold;
		@(posedge i_clk_sys) disable iff (i_rst)
		!i_cmd.set_addr |=> $stable(rca_q);
	endproperty
	a_rca_hold: assert property (p_rca_hold)
		else $error("address changed without a set command");

	property p_rca_load;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_cmd.set_addr && arg_addr != 16'h0000 |=> rca_q == $past(arg_addr);
	endproperty
	a_rca_load: assert property (p_rca_load)
		else $error("assigned address not stored");

	property p_standby;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_cmd.select && arg_addr == 16'h0000 |=> !selected_q && rca_q != 16'h0000;
	endproperty
	a_standby: assert property (p_standby)
		else $error("reserved select left card selected");

	property p_fields;
		@(posedge i_clk_sys) disable iff (i_rst)
		o_desc_ready |-> desc_word_q[127:126] == 2'h1 && desc_word_q[125:122] == 4'h2
			&& desc_word_q[121:120] == 2'h0 && desc_word_q[95:84] == 12'h007
			&& desc_word_q[9:8] == 2'h0 && desc_word_q[76] == 1'b0;
	endproperty
	a_fields: assert property (p_fields)
		else $error("descriptor fields wrong");

	property p_access_bytes;
		@(posedge i_clk_sys) disable iff (i_rst)
		o_desc_ready |-> desc_word_q[119:112] == 8'h08 && desc_word_q[111:104] == 8'h03
			&& desc_word_q[103:96] == 8'h2a && desc_word_q[83:80] == 4'hb;
	endproperty
	a_access_bytes: assert property (p_access_bytes)
		else $error("access or rate bytes wrong");

	property p_frozen;
		@(posedge i_clk_sys) disable iff (i_rst)
		o_desc_ready |=> $stable(desc_word_q) && o_desc_ready;
	endproperty
	a_frozen: assert property (p_frozen)
		else $error("descriptor changed after load");

	property p_msb_first;
		@(posedge i_clk_sys) disable iff (i_rst)
		desc_valid_q |-> o_desc_bit == exp_q[127];
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("descriptor bit out of order");

	property p_reject;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_cmd.write_req |=> o_write_reject ##1 !$past(i_cmd.write_req) || o_write_reject;
	endproperty
	a_reject: assert property (p_reject)
		else $error("write command not refused");

	property p_deadline;
		@(posedge i_clk_sys) disable iff (i_rst)
		read_go_q |-> ##[1:302] (read_valid_q || tmr_expired);
	endproperty
	a_deadline: assert property (p_deadline)
		else $error("read neither delivered nor timed out");

	property p_partial;
		@(posedge i_clk_sys) disable iff (i_rst)
		i_cmd.set_blen && i_cmd.arg == 32'h1 |=> !blk_err_q && blk_len_q == 12'h001;
	endproperty
	a_partial: assert property (p_partial)
		else $error("one-byte block refused");

endmodule

// *** pkg/cadr_pkg.sv ***
// constants, field layout and carrier types of the card address and descriptor registers
// assumes a command decoder on the same card bus clock that delivers decoded command strobes
package cadr_pkg;

	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned DESC_W = 128;
	localparam int unsigned DESC_BODY_W = 120;
	localparam int unsigned CRC_W = 7;

	// address register
	localparam logic [15:0] RCA_DEFAULT = 16'h0001;
	localparam logic [15:0] RCA_RESERVED = 16'h0000;
	localparam int unsigned RCA_ARG_LSB = 16;

	// descriptor field values
	localparam logic [1:0] STRUCT_VERSION = 2'h1;
	localparam logic [3:0] PROTOCOL_VERSION = 4'h2;
	localparam logic [7:0] ASYNC_ACCESS_CODE = 8'h08;
	localparam logic [7:0] CLOCKED_ACCESS_CODE = 8'h03;
	localparam logic [7:0] MAX_TRANSFER_RATE = 8'h2a;
	localparam logic [11:0] SUPPORTED_CLASSES = 12'h007;
	localparam logic [3:0] READ_BLOCK_LENGTH_CODE_CODE = 4'hb;
	localparam logic PARTIAL_READ_FLAG = 1'b1;
	localparam logic CROSS_BOUNDARY_FLAG = 1'b1;
	localparam logic DRIVER_STAGE_FLAG = 1'b0;
	localparam logic [11:0] CAPACITY_SIZE = 12'h001;
	localparam logic [2:0] READ_CURR_MIN = 3'h4;
	localparam logic [2:0] READ_CURR_MAX = 3'h4;
	localparam logic [2:0] CAPACITY_MULT = 3'h7;
	localparam logic FILE_FMT_GROUP = 1'b0;
	localparam logic PERM_PROTECT = 1'b1;
	localparam logic TEMP_PROTECT = 1'b1;
	localparam logic [1:0] FILE_FMT = 2'h0;
	localparam logic [1:0] ECC_TYPE = 2'h0;
	localparam logic END_BIT = 1'b1;

	// field positions checked by logic
	localparam int unsigned PERM_PROTECT_POS = 13;
	localparam int unsigned TEMP_PROTECT_POS = 12;

	// descriptor bits 127..8, unused fields forced to zero
	localparam logic [DESC_BODY_W-1:0] DESC_BODY = {STRUCT_VERSION, PROTOCOL_VERSION, 2'h0,
		ASYNC_ACCESS_CODE, CLOCKED_ACCESS_CODE, MAX_TRANSFER_RATE, SUPPORTED_CLASSES,
		READ_BLOCK_LENGTH_CODE_CODE, PARTIAL_READ_FLAG, 1'b0, CROSS_BOUNDARY_FLAG, DRIVER_STAGE_FLAG,
		2'h0, CAPACITY_SIZE, READ_CURR_MIN, READ_CURR_MAX, 6'h00, CAPACITY_MULT, 31'h0,
		FILE_FMT_GROUP, 1'b0, PERM_PROTECT, TEMP_PROTECT, FILE_FMT, ECC_TYPE};

	// access time: 1.0 x 1 ns async part, rounded down but never below one cycle
	localparam int unsigned ASYNC_ACCESS_NS = 1;
	localparam int unsigned ASYNC_CYCLES = (ASYNC_ACCESS_NS / CLK_PERIOD_NS) < 1 ? 1 :
		ASYNC_ACCESS_NS / CLK_PERIOD_NS;
	localparam int unsigned NAC_PER_UNIT = 100;
	localparam int unsigned ACCESS_CYCLES = ASYNC_CYCLES + NAC_PER_UNIT * CLOCKED_ACCESS_CODE;

	// capacity in bytes
	localparam int unsigned BLK_BYTES = 1 << READ_BLOCK_LENGTH_CODE_CODE;
	localparam int unsigned CAPACITY_BYTES = (CAPACITY_SIZE + 1) * (1 << (CAPACITY_MULT + 2)) *
		BLK_BYTES;

	typedef struct packed {
		logic set_addr;
		logic select;
		logic send_desc;
		logic set_blen;
		logic read_start;
		logic write_req;
		logic [31:0] arg;
	} cadr_cmd_t;

	// idle and send share the high code bit, so the ready output is that flop alone
	typedef enum logic [1:0] {
		CADR_ST_CRC = 2'b00,
		CADR_ST_LOAD = 2'b01,
		CADR_ST_IDLE = 2'b10,
		CADR_ST_SEND = 2'b11
	} cadr_desc_st_t;

endpackage

// *** hdl/cadr_crc7.sv ***
// serial 7-bit checksum engine, generator x^7 + x^3 + 1, message most significant bit first
// assumes the caller clears it before a message and feeds one bit per enabled clock
`timescale 1ns/1ps
module cadr_crc7 (
	input wire logic i_clk_sys,
	input wire logic i_clear,
	input wire logic i_en,
	input wire logic i_bit,
	output logic [6:0] o_crc
);
	logic [6:0] crc_q;
	logic fb;

	assign fb = i_bit ^ crc_q[6];
	assign o_crc = crc_q;

	always_ff @(posedge i_clk_sys)
	begin
		if (i_clear)
		begin
			crc_q <= 7'h00;
		end
		else if (i_en)
		begin
			crc_q <= {crc_q[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
		end
	end
endmodule

// *** hdl/cadr_access_timer.sv ***
// deadline counter for one memory read: pulses o_expired when the access time runs out
// assumes i_stop comes from the memory path on the same clock
`timescale 1ns/1ps
module cadr_access_timer (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic i_stop,
	output logic o_busy,
	output logic o_expired
);
	localparam logic [8:0] LAST = 9'(cadr_pkg::ACCESS_CYCLES - 1);
	logic [8:0] cnt_q;
	logic busy_q;
	logic expired_q;

	assign o_busy = busy_q;
	assign o_expired = expired_q;

	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			cnt_q <= 9'h000;
			busy_q <= 1'b0;
			expired_q <= 1'b0;
		end
		else
		begin
			expired_q <= 1'b0;
			if (i_start)
			begin
				busy_q <= 1'b1;
				cnt_q <= 9'h000;
			end
			else if (busy_q)
			begin
				if (i_stop)
				begin
					busy_q <= 1'b0;
				end
				else if (cnt_q == LAST)
				begin
					busy_q <= 1'b0;
					expired_q <= 1'b1;
				end
				else
				begin
					cnt_q <= cnt_q + 9'h001;
				end
			end
		end
	end
endmodule

// *** testbench/cadr_host_model.sv ***
// host side model: response path taking descriptor bits and a memory array answering reads
// assumes the card registers run on the same clock; the model drives o_bit_ready and o_mem_valid on the falling edge
`timescale 1ns/1ps
module cadr_host_model (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_stall,
	input wire logic [9:0] i_mem_delay,
	input wire logic i_desc_valid,
	input wire logic i_desc_bit,
	input wire logic i_desc_last,
	input wire logic i_read_go,
	output logic o_bit_ready,
	output logic o_mem_valid,
	output logic [127:0] o_desc,
	output logic [7:0] o_frame_len,
	output logic [7:0] o_frames
);
	logic [127:0] shift_q;
	logic [7:0] cnt_q;
	logic [9:0] wait_q;

	// a slow host is ready only on every other cycle
	always @(negedge i_clk_sys)
	begin
		if (i_rst)
			o_bit_ready <= 1'b0;
		else
			o_bit_ready <= i_stall ? ~o_bit_ready : 1'b1;
	end

	always @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			cnt_q <= 8'h00;
			o_frames <= 8'h00;
		end
		else if (i_desc_valid && o_bit_ready)
		begin
			shift_q <= {shift_q[126:0], i_desc_bit};
			cnt_q <= i_desc_last ? 8'h00 : cnt_q + 8'h01;
			if (i_desc_last)
			begin
				o_desc <= {shift_q[126:0], i_desc_bit};
				o_frame_len <= cnt_q + 8'h01;
				o_frames <= o_frames + 8'h01;
			end
		end
	end

	// a delay of zero means the array never answers
	always @(negedge i_clk_sys)
	begin
		o_mem_valid <= !i_rst && !(i_read_go && i_mem_delay != 10'h000)
			&& wait_q == 10'h001;
		if (i_rst)
			wait_q <= 10'h000;
		else if (i_read_go && i_mem_delay != 10'h000)
			wait_q <= i_mem_delay;
		else if (wait_q != 10'h000)
			wait_q <= wait_q - 10'h001;
	end
endmodule

// *** testbench/card_address_descriptor_regs_tb.sv ***
// self-checking bench for the card address and descriptor registers
// assumes a 20 MHz card bus clock; commands and reset change on the falling edge
`timescale 1ns/1ps
module card_address_descriptor_regs_tb;
	localparam logic [5:0] C_ADDR = 6'h20;
	localparam logic [5:0] C_SEL = 6'h10;
	localparam logic [5:0] C_DESC = 6'h08;
	localparam logic [5:0] C_BLEN = 6'h04;
	localparam logic [5:0] C_READ = 6'h02;
	localparam logic [5:0] C_WR = 6'h01;
	logic clk, rst, stall, bit_ready, mem_valid;
	logic [9:0] mem_delay;
	cadr_pkg::cadr_cmd_t cmd;
	logic [15:0] relative_card_address;
	logic selected, desc_ready, desc_valid, desc_bit, desc_last, blk_err, addr_err;
	logic write_reject, read_go, read_valid, read_timeout;
	logic [11:0] blk_len;
	logic [127:0] desc, exp_desc;
	logic [7:0] frame_len, frames, f0;
	int err_count = 0;
	int compares = 0;

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	cadr_regs i_dut (.i_clk_sys(clk), .i_rst(rst), .i_cmd(cmd), .i_bit_ready(bit_ready),
		.i_mem_valid(mem_valid), .o_rca(relative_card_address), .o_selected(selected), .o_desc_ready(desc_ready),
		.o_desc_valid(desc_valid), .o_desc_bit(desc_bit), .o_desc_last(desc_last),
		.o_blk_len(blk_len), .o_blk_err(blk_err), .o_addr_err(addr_err),
		.o_write_reject(write_reject), .o_read_go(read_go), .o_read_valid(read_valid),
		.o_read_timeout(read_timeout));

	cadr_host_model i_host (.i_clk_sys(clk), .i_rst(rst), .i_stall(stall),
		.i_mem_delay(mem_delay), .i_desc_valid(desc_valid), .i_desc_bit(desc_bit),
		.i_desc_last(desc_last), .i_read_go(read_go), .o_bit_ready(bit_ready),
		.o_mem_valid(mem_valid), .o_desc(desc), .o_frame_len(frame_len), .o_frames(frames));

	task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("errors %0d of %0d compares", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// strobe for one cycle; the answer is settled when the task returns
	task automatic send_cmd(input logic [5:0] s, input logic [31:0] a);
		@(negedge clk);
		cmd = cadr_pkg::cadr_cmd_t'({s, a});
		@(negedge clk);
		cmd = '0;
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		while (desc_ready !== 1'b1 && n < 300)
		begin
			@(negedge clk);
			n++;
		end
		check("desc_ready", desc_ready, 1'b1);
	endtask

	task automatic get_desc(input logic st, input int k);
		int n;
		stall = st;
		f0 = frames;
		repeat (k) send_cmd(C_DESC, 32'h0);
		n = 0;
		while (frames !== f0 + 8'(k) && n < 1200)
		begin
			@(negedge clk);
			n++;
		end
		check("frames", frames, f0 + 8'(k));
		check("frame bits", frame_len, 8'h80);
		check("descriptor", desc, exp_desc);
	endtask

	task automatic do_read(input logic [31:0] a, input logic [9:0] d);
		int n;
		mem_delay = d;
		send_cmd(C_READ, a);
		check("read_go", read_go, 1'b1);
		n = 0;
		while (read_valid !== 1'b1 && read_timeout !== 1'b1 && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		// the deadline counter starts on the edge that samples the go pulse
		if (d == 10'h000)
			check("deadline", {read_timeout, read_valid, 32'(n)},
				{2'h2, cadr_pkg::ACCESS_CYCLES + 32'd1});
		else
			check("in time", {read_valid, read_timeout,
				n <= cadr_pkg::ACCESS_CYCLES + 1}, 3'h5);
	endtask

	function automatic logic [127:0] build_desc();
		logic [127:0] e;
		logic [6:0] c;
		logic fb;
		e = '0;
		e[127:126] = 2'h1;
		e[125:122] = 4'h2;
		e[119:112] = 8'h08;
		e[111:104] = 8'h03;
		e[103:96] = 8'h2a;
		e[95:84] = 12'h007;
		e[83:80] = 4'hb;
		e[79] = 1'b1;
		e[77] = 1'b1;
		e[73:62] = 12'h001;
		e[61:59] = 3'h4;
		e[58:56] = 3'h4;
		e[49:47] = 3'h7;
		e[13] = 1'b1;
		e[12] = 1'b1;
		c = 7'h00;
		for (int i = 127; i >= 8; i--)
		begin
			fb = e[i] ^ c[6];
			c = {c[5:0], 1'b0};
			if (fb)
				c = c ^ 7'h09;
		end
		e[7:1] = c;
		e[0] = 1'b1;
		return e;
	endfunction

	initial
	begin
		rst = 1'b1;
		cmd = '0;
		stall = 1'b0;
		mem_delay = 10'h003;
		exp_desc = build_desc();
		repeat (12) @(negedge clk);
		rst = 1'b0;
		check("rca reset", relative_card_address, 16'h0001);
		check("blk_len reset", blk_len, 12'h800);
		wait_ready();
		get_desc(1'b0, 1);
		check("valid drop", desc_valid, 1'b0);
		// stalled host, second request arrives during the first transfer
		get_desc(1'b1, 2);
		check("structure", desc[127:126], 2'h1);
		check("protocol", desc[125:122], 4'h2);
		check("async time", desc[119:112], 8'h08);
		check("clocked time", desc[111:104], 8'h03);
		check("rate", desc[103:96], 8'h2a);
		check("classes", desc[95:84], 12'h007);
		check("blk code", desc[83:80], 4'hb);
		check("partial", desc[79], 1'b1);
		check("cross", desc[77], 1'b1);
		check("driver stage", desc[76], 1'b0);
		check("capacity", ((128'(desc[73:62]) + 128'h1) << (32'(desc[49:47]) + 2))
			<< desc[83:80], 128'h20_0000);
		check("protect", desc[13:12], 2'h3);
		check("ecc", desc[9:8], 2'h0);
		check("checksum", desc[7:1], exp_desc[7:1]);
		send_cmd(C_ADDR, 32'h1234_0000);
		check("rca set", relative_card_address, 16'h1234);
		send_cmd(C_ADDR, 32'h0000_0000);
		check("rca zero", relative_card_address, 16'h1234);
		send_cmd(C_READ, 32'h0);
		check("go unselected", read_go, 1'b0);
		send_cmd(C_SEL, 32'h1234_0000);
		check("selected", selected, 1'b1);
		send_cmd(C_SEL, 32'h0000_0000);
		check("standby", selected, 1'b0);
		send_cmd(C_SEL, 32'h1234_0000);
		send_cmd(C_BLEN, 32'h0000_0001);
		check("blen 1", {blk_err, blk_len}, 13'h1);
		send_cmd(C_BLEN, 32'h0000_0801);
		check("blen over", {blk_err, blk_len}, 13'h1001);
		do_read(32'h001f_ffff, 10'h003);
		do_read(32'h0000_0000, 10'h0fa);
		do_read(32'h0000_0010, 10'h000);
		send_cmd(C_READ, 32'h0020_0000);
		check("range", {addr_err, read_go}, 2'h2);
		send_cmd(C_WR, 32'h0);
		check("write reject", write_reject, 1'b1);
		@(negedge clk);
		check("reject pulse", write_reject, 1'b0);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		check("rca default", {relative_card_address, selected}, 17'h2);
		check("ready low", desc_ready, 1'b0);
		// request during the checksum pass is held and served once ready
		get_desc(1'b0, 1);
		wait_ready();
		complete_run();
	end

	// the whole sequence needs well under 5000 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		complete_run();
	end
endmodule
